// ==== logic/argen_div.sv ====
// Iterative restoring divider for output scaling
`timescale 1ns/10ps
`default_nettype none
module argen_div #(
  parameter int W = 24
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  output logic              busy,
  output logic              done,
  output logic [W-1:0]      quotient
);
  import argen_pkg::*;

  typedef struct packed {
    logic         busy;
    logic         done;
    logic [7:0]   cnt;
    logic [W:0]   rem;
    logic [W-1:0] quo;
    logic [W-1:0] dvs;
  } argen_div_st_t;

  argen_div_st_t st_reg;
  argen_div_st_t st_next;

  // ----------------------------------------------------------------
  // One quotient bit per cycle; divisor zero yields all ones
  // ----------------------------------------------------------------
  always_comb begin
    logic [W:0] trial;
    trial = '0;
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy) begin
      if (start) begin
        st_next.busy = 1'b1;
        st_next.cnt  = 8'(W);
        st_next.rem  = '0;
        st_next.quo  = dividend;
        st_next.dvs  = divisor;
      end
    end else begin
      trial = {st_reg.rem[W-1:0], st_reg.quo[W-1]} - {1'b0, st_reg.dvs};
      if (!trial[W]) begin
        st_next.rem = trial;
        st_next.quo = {st_reg.quo[W-2:0], 1'b1};
      end else begin
        st_next.rem = {st_reg.rem[W-1:0], st_reg.quo[W-1]};
        st_next.quo = {st_reg.quo[W-2:0], 1'b0};
      end
      st_next.cnt = st_reg.cnt - 8'h01;
      if (st_reg.cnt == 8'h01) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy     = st_reg.busy;
  assign done     = st_reg.done;
  assign quotient = st_reg.quo;
endmodule
`default_nettype wire

// ==== logic/argen_pkg.sv ====
// Shared constants and types of the analog ramp generator
package argen_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_MS     = 100;                       // Update period
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;  // Cycles per update
  localparam int HOLD_MS     = 100;                       // Plateau hold time
  localparam logic [1:0] HOLD_TICKS = 2'(HOLD_MS / TICK_MS);
  localparam int RATE_DIV    = 1000 / TICK_MS;            // Updates per second
  localparam int SCALE_HUND  = 100;                       // Gain is in hundredths

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_PRIMARY   = 8'h04;
  localparam logic [7:0] OFS_SECONDARY = 8'h08;
  localparam logic [7:0] OFS_CEILING   = 8'h0C;
  localparam logic [7:0] OFS_BIAS      = 8'h10;
  localparam logic [7:0] OFS_RATE      = 8'h14;
  localparam logic [7:0] OFS_GAIN      = 8'h18;
  localparam logic [7:0] OFS_OFFSET    = 8'h1C;
  localparam logic [7:0] OFS_LEVEL     = 8'h20;
  localparam logic [7:0] OFS_SCALED    = 8'h24;
  localparam logic [7:0] OFS_STATUS    = 8'h28;

  // ----------------------------------------------------------------
  // Ranges and reset values
  // ----------------------------------------------------------------
  localparam logic signed [17:0] GOAL_MIN   = -18'sd10000;
  localparam logic signed [17:0] GOAL_MAX   = 18'sd20000;
  localparam logic signed [17:0] BIAS_MIN   = 18'sd0;
  localparam logic signed [17:0] OFFSET_MIN = -18'sd10000;
  localparam logic signed [17:0] OFFSET_MAX = 18'sd10000;
  localparam logic signed [17:0] RATE_MIN   = 18'sd1;
  localparam logic signed [17:0] RATE_MAX   = 18'sd10000;
  localparam logic signed [17:0] GAIN_MIN   = 18'sd0;
  localparam logic signed [17:0] GAIN_MAX   = 18'sd1000;
  localparam logic [15:0] SCALED_MAX        = 16'h7FFF;

  localparam logic signed [15:0] PRIMARY_RST   = 16'sh0000;
  localparam logic signed [15:0] SECONDARY_RST = 16'sh0000;
  localparam logic signed [15:0] CEILING_RST   = 16'sh4E20;
  localparam logic signed [15:0] BIAS_RST      = 16'sh0000;
  localparam logic [13:0]        RATE_RST      = 14'h0064;
  localparam logic [10:0]        GAIN_RST      = 11'h064;
  localparam logic signed [15:0] OFFSET_RST    = 16'sh0000;
  localparam logic [1:0]         DECIMALS_RST  = 2'h0;

  // ----------------------------------------------------------------
  // Ramp states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ARGEN_OFF   = 3'b000,
    ARGEN_START = 3'b001,
    ARGEN_RAMP  = 3'b010,
    ARGEN_DECEL = 3'b011,
    ARGEN_STOP  = 3'b100
  } argen_state_t;

endpackage

// ==== logic/argen_ramp.sv ====
// Analog ramp generator with AHB-Lite register slave
//
// What this block does
// - Enable rising: level becomes plateau, held 100 to 200 ms, then ramps to target.
// - Enable falling: level forced to offset at once, scaled output zero.
// - Pick low selects primary goal, pick high selects secondary goal.
// - Pick change: level moves toward newly chosen goal at programmed rate.
// - Halt rising: ramp down to plateau, hold 100 ms, then level to offset.
// - After a halt request, no restart until halt and enable both low.
// - Goal values are accepted within -10000 to +20000.
// - Level never exceeds the ceiling, settable -10000 to +20000.
// - Plateau is offset plus bias; bias 0 to +20000.
// - Rate in steps per second, settable 1 to 10000.
// - Gain 0 to 10.00 and offset within plus or minus 10000.
// - Scaled output is (level minus offset) divided by gain, 0 to 32767.
// - Level stepped once per 100 ms; enable edges and the ceiling guard act at once.
// - Viewing port shows the unscaled current level.
// - Decimal places only affect presentation, never computation.
`timescale 1ns/10ps
`default_nettype none
module argen_ramp #(
  parameter int TICK_LEN = argen_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        levelPick,
  input  wire logic        softHalt,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic [15:0]      scaledOut,
  output logic [15:0]      levelView,
  output argen_pkg::argen_state_t rampState
);
  import argen_pkg::*;

  localparam int CW = $clog2(TICK_LEN + 1);
  localparam int DW = 24;

  typedef struct packed {
    logic [2:0]         meta;      // First sync stage: en, pick, halt
    logic [2:0]         sync;      // Second sync stage
    logic [2:0]         prev;      // Previous synced value
    argen_state_t       fsm;
    logic signed [15:0] level;
    logic [CW-1:0]      tickCnt;
    logic               tick;
    logic [1:0]         hold;
    logic               lockout;
    logic signed [15:0] primary;
    logic signed [15:0] secondary;
    logic signed [15:0] ceiling;
    logic signed [15:0] bias;
    logic [13:0]        rate;
    logic [10:0]        gain;
    logic signed [15:0] offset;
    logic [1:0]         decimals;
    logic               wrPend;
    logic [7:0]         wrAddr;
    logic               hreadyout;
    logic               hresp;
    logic [31:0]        hrdata;
    logic [15:0]        scaled;
    logic               divStart;
  } argen_ramp_st_t;

  argen_ramp_st_t st_reg;
  argen_ramp_st_t st_next;

  logic          divBusy;
  logic          divDone;
  logic [DW-1:0] divQuo;
  logic [DW-1:0] dividend;
  logic signed [17:0] numer;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Limit a written value to its legal range
  function automatic logic signed [15:0] clampVal(input logic signed [17:0] v,
                                                  input logic signed [17:0] lo,
                                                  input logic signed [17:0] hi);
    logic signed [17:0] r;
    r = v;
    if (r < lo) r = lo;
    if (r > hi) r = hi;
    return r[15:0];
  endfunction

  // One step toward a goal, stopping exactly on it
  function automatic logic signed [15:0] moveToward(input logic signed [15:0] cur,
                                                    input logic signed [15:0] tgt,
                                                    input logic signed [17:0] step);
    logic signed [17:0] c;
    logic signed [17:0] t;
    c = 18'(cur);
    t = 18'(tgt);
    if (c < t) c = (c + step > t) ? t : c + step;
    else if (c > t) c = (c - step < t) ? t : c - step;
    return c[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Scaling divider: (level - offset) * 100 / gain
  // ----------------------------------------------------------------
  assign numer    = 18'(st_reg.level) - 18'(st_reg.offset);
  assign dividend = (numer <= 18'sd0) ? '0 : DW'(numer) * DW'(SCALE_HUND);

  argen_div #(.W(DW)) u_div (
    .clk      (clk),
    .rst      (rst),
    .start    (st_reg.divStart),
    .dividend (dividend),
    .divisor  (DW'(st_reg.gain)),
    .busy     (divBusy),
    .done     (divDone),
    .quotient (divQuo)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [17:0] plat;
    logic signed [15:0] plateau;
    logic signed [15:0] goal;
    logic signed [15:0] target;
    logic signed [17:0] step;
    logic signed [15:0] nxt;
    logic enRise;
    logic enFall;
    logic haltRise;
    logic pickChg;
    logic [17:0] wv;
    plat = '0;
    plateau = '0;
    goal = '0;
    target = '0;
    step = '0;
    nxt = '0;
    wv = '0;
    enRise   = st_reg.sync[0] & ~st_reg.prev[0];
    enFall   = ~st_reg.sync[0] & st_reg.prev[0];
    haltRise = st_reg.sync[2] & ~st_reg.prev[2];
    pickChg  = st_reg.sync[1] ^ st_reg.prev[1];
    st_next = st_reg;

    // Input synchronisers; edges above come from the second stage only
    st_next.meta = {softHalt, levelPick, enable};
    st_next.sync = st_reg.meta;
    st_next.prev = st_reg.sync;

    // Update tick divider
    st_next.tick = 1'b0;
    if (st_reg.tickCnt == CW'(TICK_LEN - 1)) begin
      st_next.tickCnt = '0;
      st_next.tick    = 1'b1;
    end else begin
      st_next.tickCnt = st_reg.tickCnt + CW'(1);
    end

    // Derived levels
    plat = 18'(st_reg.offset) + 18'(st_reg.bias);
    plateau = (plat > 18'(st_reg.ceiling)) ? st_reg.ceiling : plat[15:0];
    goal = st_reg.sync[1] ? st_reg.secondary : st_reg.primary;
    target = (goal > st_reg.ceiling) ? st_reg.ceiling : goal;
    step = 18'(st_reg.rate) / 18'sd10;
    if (step < 18'sd1) step = 18'sd1;

    // Ramp sequencer
    if (enFall) begin
      st_next.level = st_reg.offset;
      st_next.fsm   = ARGEN_OFF;
    end else begin
      case (st_reg.fsm)
        ARGEN_OFF: begin
          if (enRise && !st_reg.lockout) begin
            st_next.level = plateau;
            st_next.hold  = HOLD_TICKS;
            st_next.fsm   = ARGEN_START;
          end
        end
        ARGEN_START: begin
          if (haltRise) begin
            st_next.fsm = ARGEN_DECEL;
          end else if (st_reg.tick) begin
            if (st_reg.hold == 2'h0) begin
              st_next.level = moveToward(st_reg.level, target, step);
              st_next.fsm   = ARGEN_RAMP;
            end else begin
              st_next.hold = st_reg.hold - 2'h1;
            end
          end
        end
        ARGEN_RAMP: begin
          if (haltRise) begin
            st_next.fsm = ARGEN_DECEL;
          end else if (st_reg.tick) begin
            // Target follows the pick input, so a change retargets here
            st_next.level = moveToward(st_reg.level, target, step);
          end
        end
        ARGEN_DECEL: begin
          if (st_reg.tick) begin
            nxt = moveToward(st_reg.level, plateau, step);
            st_next.level = nxt;
            if (nxt == plateau) begin
              st_next.hold = HOLD_TICKS - 2'h1;                  // Entry tick starts the hold
              st_next.fsm  = ARGEN_STOP;
            end
          end
        end
        ARGEN_STOP: begin
          if (st_reg.tick) begin
            if (st_reg.hold == 2'h0) begin
              st_next.level = st_reg.offset;
              st_next.fsm   = ARGEN_OFF;
            end else begin
              st_next.hold = st_reg.hold - 2'h1;
            end
          end
        end
        default: begin
          st_next.fsm = ARGEN_OFF;
        end
      endcase
    end
    if (pickChg && st_reg.fsm == ARGEN_RAMP) begin
      st_next.hold = '0;
    end

    // Restart lock: set wins over release
    if (!st_reg.sync[0] && !st_reg.sync[2]) st_next.lockout = 1'b0;
    if (haltRise) st_next.lockout = 1'b1;

    // Ceiling guard
    if (st_next.level > st_reg.ceiling) st_next.level = st_reg.ceiling;

    // Scaled result capture with saturation
    st_next.divStart = !divBusy && !st_reg.divStart && !divDone;
    if (numer <= 18'sd0) begin
      st_next.scaled = '0;
    end else if (divDone) begin
      st_next.scaled = (divQuo > DW'(SCALED_MAX)) ? SCALED_MAX : divQuo[15:0];
    end

    // AHB-Lite data phase of a write
    st_next.wrPend = 1'b0;
    if (st_reg.wrPend) begin
      wv = hwdata[17:0];
      case (st_reg.wrAddr)
        OFS_CTRL:      st_next.decimals  = hwdata[1:0];
        OFS_PRIMARY:   st_next.primary   = clampVal(wv, GOAL_MIN, GOAL_MAX);
        OFS_SECONDARY: st_next.secondary = clampVal(wv, GOAL_MIN, GOAL_MAX);
        OFS_CEILING:   st_next.ceiling   = clampVal(wv, GOAL_MIN, GOAL_MAX);
        OFS_BIAS:      st_next.bias      = clampVal(wv, BIAS_MIN, GOAL_MAX);
        OFS_RATE:      st_next.rate      = 14'(clampVal(wv, RATE_MIN, RATE_MAX));
        OFS_GAIN:      st_next.gain      = 11'(clampVal(wv, GAIN_MIN, GAIN_MAX));
        OFS_OFFSET:    st_next.offset    = clampVal(wv, OFFSET_MIN, OFFSET_MAX);
        default:       st_next.wrPend    = 1'b0;
      endcase
    end

    // AHB-Lite address phase; read data is registered for the data phase
    st_next.hrdata = 32'h0000_0000;
    if (hsel && htrans[1] && hready) begin
      st_next.wrPend = hwrite && (haddr[31:8] == 24'h000000);
      st_next.wrAddr = {haddr[7:2], 2'b00};
      if (!hwrite && haddr[31:8] == 24'h000000) begin
        case ({haddr[7:2], 2'b00})
          OFS_CTRL:      st_next.hrdata = {30'h0, st_reg.decimals};
          OFS_PRIMARY:   st_next.hrdata = 32'(st_reg.primary);
          OFS_SECONDARY: st_next.hrdata = 32'(st_reg.secondary);
          OFS_CEILING:   st_next.hrdata = 32'(st_reg.ceiling);
          OFS_BIAS:      st_next.hrdata = 32'(st_reg.bias);
          OFS_RATE:      st_next.hrdata = {18'h0, st_reg.rate};
          OFS_GAIN:      st_next.hrdata = {21'h0, st_reg.gain};
          OFS_OFFSET:    st_next.hrdata = 32'(st_reg.offset);
          OFS_LEVEL:     st_next.hrdata = 32'(st_reg.level);
          OFS_SCALED:    st_next.hrdata = {16'h0, st_reg.scaled};
          OFS_STATUS:    st_next.hrdata = {24'h0, st_reg.lockout, st_reg.sync[2:1],
                                           st_reg.sync[0], 1'b0, st_reg.fsm};
          default:       st_next.hrdata = 32'h0000_0000;
        endcase
      end
    end
    st_next.hreadyout = 1'b1;
    st_next.hresp     = 1'b0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.fsm       <= ARGEN_OFF;
      st_reg.primary   <= PRIMARY_RST;
      st_reg.secondary <= SECONDARY_RST;
      st_reg.ceiling   <= CEILING_RST;
      st_reg.bias      <= BIAS_RST;
      st_reg.rate      <= RATE_RST;
      st_reg.gain      <= GAIN_RST;
      st_reg.offset    <= OFFSET_RST;
      st_reg.decimals  <= DECIMALS_RST;
      st_reg.hreadyout <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = st_reg.hreadyout;
  assign hresp     = st_reg.hresp;
  assign hrdata    = st_reg.hrdata;
  assign scaledOut = st_reg.scaled;
  assign levelView = st_reg.level;
  assign rampState = st_reg.fsm;

  // hsize is accepted without check: only word transfers are used
  logic unusedSize;
  assign unusedSize = ^hsize;
endmodule
`default_nettype wire

// ==== tb/argen_pin_src.sv ====
// Far-side model: input signals from other controller blocks
`timescale 1ns/10ps
`default_nettype none
module argen_pin_src (
  input  wire logic clk,
  input  wire logic wantEn,
  input  wire logic wantPick,
  input  wire logic wantHalt,
  output logic      enable,
  output logic      levelPick,
  output logic      softHalt
);
  logic [1:0] quiet;

  initial begin
    enable = 1'b0;
    levelPick = 1'b0;
    softHalt = 1'b0;
    quiet = 2'h0;
  end

  // Pins change only after two quiet cycles, so no short pulse reaches the sync
  always @(posedge clk) begin
    if (quiet != 2'h0) begin
      quiet <= quiet - 2'h1;
    end else if ({wantEn, wantPick, wantHalt} != {enable, levelPick, softHalt}) begin
      enable <= wantEn;
      levelPick <= wantPick;
      softHalt <= wantHalt;
      quiet <= 2'h2;
    end
  end
endmodule
`default_nettype wire

// ==== tb/argen_ramp_props.sv ====
// Concurrent checks on the ports of the ramp generator
`timescale 1ns/10ps
`default_nettype none
module argen_ramp_props #(
  parameter int TICK_LEN = 20
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    enable,
  input wire logic                    levelPick,
  input wire logic                    softHalt,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic [2:0]              hsize,
  input wire logic [31:0]             hwdata,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire logic [31:0]             hrdata,
  input wire logic [15:0]             scaledOut,
  input wire logic [15:0]             levelView,
  input wire argen_pkg::argen_state_t rampState
);
  import argen_pkg::*;

  logic [31:0]  age;
  logic [31:0]  sinceChg;
  logic [15:0]  prevLv;
  argen_state_t prevSt;

  // Cycles spent in the present state and since the last level change
  always_ff @(posedge clk) begin
    if (rst) begin
      age <= 32'h00000000;
      sinceChg <= 32'h00000000;
      prevLv <= 16'h0000;
      prevSt <= ARGEN_OFF;
    end else begin
      age <= (rampState != prevSt) ? 32'h00000000 : age + 32'h00000001;
      sinceChg <= (levelView != prevLv) ? 32'h00000000 : sinceChg + 32'h00000001;
      prevLv <= levelView;
      prevSt <= rampState;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_EN_FALL_OFF: assert property (
    $fell(enable) |-> ##[1:6] rampState == ARGEN_OFF)
    else $error("state not off after enable fall");
  AST_EN_FALL_ZERO: assert property (
    $fell(enable) |-> ##[1:60] scaledOut == 16'h0000)
    else $error("scaled output not zero after enable fall");
  AST_PLATEAU_HELD: assert property (
    rampState == ARGEN_START && prevSt == ARGEN_START |-> levelView == prevLv)
    else $error("level moved during start plateau");
  AST_PLATEAU_LEN: assert property (
    rampState == ARGEN_RAMP && prevSt == ARGEN_START
    |-> age >= TICK_LEN - 2 && age <= 2 * TICK_LEN + 2)
    else $error("start plateau length wrong");
  AST_TICK_ONLY: assert property (
    rampState == ARGEN_RAMP && prevSt == ARGEN_RAMP && levelView != prevLv
    |-> sinceChg >= TICK_LEN - 2)
    else $error("level changed between update ticks");
  AST_HALT_DECEL: assert property (
    $rose(softHalt) && enable && rampState == ARGEN_RAMP |-> ##[1:6] rampState == ARGEN_DECEL)
    else $error("halt did not start deceleration");
  AST_STOP_HOLD: assert property (
    rampState == ARGEN_OFF && prevSt == ARGEN_STOP && enable && $past(enable, 4)
    |-> age >= TICK_LEN - 2 && age <= TICK_LEN + 2)
    else $error("stop plateau length wrong");
  AST_LOCKOUT: assert property (
    rampState == ARGEN_OFF && softHalt && $past(softHalt, 4) |=> rampState == ARGEN_OFF)
    else $error("restart while halt request active");
  AST_SCALED_RANGE: assert property (
    scaledOut <= SCALED_MAX)
    else $error("scaled output above range");
  AST_BUS_OKAY: assert property ( // Zero-wait OKAY answer
    hreadyout == 1'b1 && hresp == 1'b0)
    else $error("bus answer not ready or not okay");
endmodule
`default_nettype wire

// ==== tb/test_analog_ramp_generator.sv ====
// Self-checking testbench of the ramp generator
`timescale 1ns/10ps
`default_nettype none
module test_analog_ramp_generator;
  import argen_pkg::*;

  localparam int TL = 20;

  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         wantEn = 1'b0;
  logic         wantPick = 1'b0;
  logic         wantHalt = 1'b0;
  logic         enable;
  logic         levelPick;
  logic         softHalt;
  logic         hsel = 1'b0;
  logic [31:0]  haddr = 32'h00000000;
  logic [1:0]   htrans = 2'b00;
  logic         hwrite = 1'b0;
  logic [2:0]   hsize = 3'b010;
  logic [31:0]  hwdata = 32'h00000000;
  wire logic    hready;
  logic         hreadyout;
  logic         hresp;
  logic [31:0]  hrdata;
  logic [15:0]  scaledOut;
  logic [15:0]  levelView;
  argen_state_t rampState;
  int           badCount = 0;
  int           samplesChecked = 0;

  assign hready = hreadyout;

  // 50 MHz clock
  always #10 clk = ~clk;

  argen_pin_src pins (.clk(clk), .wantEn(wantEn), .wantPick(wantPick), .wantHalt(wantHalt),
    .enable(enable), .levelPick(levelPick), .softHalt(softHalt));

  argen_ramp #(.TICK_LEN(TL)) dut (.clk(clk), .rst(rst), .enable(enable),
    .levelPick(levelPick), .softHalt(softHalt), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .scaledOut(scaledOut), .levelView(levelView),
    .rampState(rampState));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic busOp(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
    logic [31:0] d;
    busOp(1'b1, {24'h000000, ofs}, wd, d);
  endtask

  task automatic rdChk(input logic [7:0] ofs, input logic [31:0] exp);
    logic [31:0] d;
    busOp(1'b0, {24'h000000, ofs}, 32'h00000000, d);
    chk(d, exp);
  endtask

  task automatic waitSt(input argen_state_t s);
    int n;
    n = 0;
    while (rampState !== s && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(rampState), 32'(s));
  endtask

  task automatic waitLv(input logic [15:0] v);
    int n;
    n = 0;
    while (levelView !== v && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(32'(levelView), 32'(v));
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testRegs();
    logic [31:0] d;
    rdChk(OFS_CEILING, 32'h00004E20);
    rdChk(OFS_GAIN, 32'h00000064);
    wr(OFS_RATE, 32'h00004E20);
    rdChk(OFS_RATE, 32'h00002710);
    wr(OFS_PRIMARY, 32'h00007530);
    rdChk(OFS_PRIMARY, 32'h00004E20);
    wr(OFS_OFFSET, 32'hFFFFB1E0);
    rdChk(OFS_OFFSET, 32'hFFFFD8F0);
    wr(OFS_LEVEL, 32'h00000055);
    rdChk(OFS_LEVEL, 32'h00000000);
    busOp(1'b0, 32'h00000100, 32'h00000000, d);
    chk(d, 32'h00000000);
  endtask

  task automatic testRamp();
    wr(OFS_CTRL, 32'h00000003);
    wr(OFS_OFFSET, 32'h00000064);
    wr(OFS_BIAS, 32'h00000032);
    wr(OFS_RATE, 32'h00000064);
    wr(OFS_GAIN, 32'h000000C8);
    wr(OFS_PRIMARY, 32'h0000012C);
    wr(OFS_SECONDARY, 32'h000000C8);
    wantEn <= 1'b1;
    waitSt(ARGEN_START);
    repeat (4) @(posedge clk);
    chk(32'(levelView), 32'h00000096);
    waitLv(16'h00A0);
    waitLv(16'h012C);
    repeat (3 * TL) @(posedge clk);
    chk(32'(levelView), 32'h0000012C);
    chk(32'(scaledOut), 32'h00000064);
    rdChk(OFS_LEVEL, 32'h0000012C);
    rdChk(OFS_SCALED, 32'h00000064);
    rdChk(OFS_CTRL, 32'h00000003);
    wr(OFS_GAIN, 32'h00000000);
    repeat (60) @(posedge clk);
    chk(32'(scaledOut), 32'h00007FFF);
    wr(OFS_GAIN, 32'h000000C8);
    wantPick <= 1'b1;
    waitLv(16'h0122);
    waitLv(16'h00C8);
    repeat (3 * TL) @(posedge clk);
    chk(32'(levelView), 32'h000000C8);
  endtask

  task automatic testCeil();
    wr(OFS_CEILING, 32'h000000FA);
    wantPick <= 1'b0;
    waitLv(16'h00FA);
    repeat (5 * TL) @(posedge clk);
    chk(32'(levelView), 32'h000000FA);
    wr(OFS_CEILING, 32'h00004E20);
  endtask

  task automatic testHalt();
    wantHalt <= 1'b1;
    waitSt(ARGEN_STOP);
    repeat (4) @(posedge clk);
    chk(32'(levelView), 32'h00000096);
    waitSt(ARGEN_OFF);
    repeat (60) @(posedge clk);
    chk(32'(levelView), 32'h00000064);
    chk(32'(scaledOut), 32'h00000000);
    rdChk(OFS_STATUS, 32'h000000D0);
    // Enable toggled while halt still high must not restart
    wantEn <= 1'b0;
    repeat (10) @(posedge clk);
    wantEn <= 1'b1;
    repeat (10) @(posedge clk);
    chk(32'(rampState), 32'(ARGEN_OFF));
    wantHalt <= 1'b0;
    repeat (5 * TL) @(posedge clk);
    chk(32'(rampState), 32'(ARGEN_OFF));
    wantEn <= 1'b0;
    repeat (10) @(posedge clk);
    wantEn <= 1'b1;
    waitSt(ARGEN_START);
  endtask

  task automatic testDrop();
    waitSt(ARGEN_RAMP);
    repeat (TL) @(posedge clk);
    wantEn <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(levelView), 32'h00000064);
    chk(32'(rampState), 32'(ARGEN_OFF));
    repeat (60) @(posedge clk);
    chk(32'(scaledOut), 32'h00000000);
  endtask

  task automatic testDone();
    $display("checks %0d, mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    testRegs();
    testRamp();
    testCeil();
    testHalt();
    testDrop();
    testDone();
  end

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    badCount++;
    testDone();
  end
endmodule

bind argen_ramp argen_ramp_props #(.TICK_LEN(TICK_LEN)) props (.clk(clk), .rst(rst),
  .enable(enable), .levelPick(levelPick), .softHalt(softHalt), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scaledOut(scaledOut),
  .levelView(levelView), .rampState(rampState));
`default_nettype wire
